// >>> rtl/spi_memory_fifo_instruction_unit.sv
`default_nettype none
module spi_memory_fifo_instruction_unit #(
	parameter logic [11:0] MEM_TOP = spi_instr_pkg::MEM_TOP_DEFAULT
) (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire spi_instr_pkg::spi_pins_s pins,
	output logic                          miso,
	output logic                          miso_oe,
	output spi_instr_pkg::mem_req_s       mem_req,
	input  wire logic [7:0]               mem_rdata,
	input  wire logic [7:0]               rx_count,
	input  wire logic [7:0]               rx_data,
	output logic                          rx_pop,
	output logic [15:0]                   rx_enable_mask,
	output spi_instr_pkg::exc_s           exc
);
	import spi_instr_pkg::*;

	// ----------------------------------------
	// link
	// ----------------------------------------
	logic       start;
	logic       done;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;
	logic       load;

	spi_byte_shifter shifter (
		.clk     (clk),
		.rst_b   (rst_b),
		.pins    (pins),
		.tx_byte (tx_byte),
		.load    (load),
		.start   (start),
		.done    (done),
		.rx_byte (rx_byte),
		.miso    (miso),
		.miso_oe (miso_oe)
	);

	// ----------------------------------------
	// instruction state
	// ----------------------------------------
	state_e      state,     next_state;
	kind_e       kind,      next_kind;
	logic [11:0] addr,      next_addr;
	logic [7:0]  mask_hi,   next_mask_hi;
	logic [15:0] mask,      next_mask;
	logic [7:0]  hold,      next_hold;
	logic [11:0] hold_addr, next_hold_addr;
	logic        hold_valid, next_hold_valid;
	logic        step,      next_step;
	exc_s        next_exc;
	logic [7:0]  status_byte;
	logic [15:0] and_result;
	logic [11:0] addr_inc;
	logic        in_range;
	logic        hold_hit;
	logic        mem_kind;
	logic        rx_kind;

	assign rx_enable_mask = mask;
	assign and_result     = mask & {mask_hi, rx_byte};
	assign addr_inc       = addr + 12'h001;
	assign in_range       = addr <= MEM_TOP;
	assign hold_hit       = hold_valid && (hold_addr == addr);
	assign mem_kind       = (kind == K_READ) || (kind == K_WRITE) || (kind == K_XOR);
	assign rx_kind        = (kind == K_RX_READ) || (kind == K_RX_COPY);

	// status byte shows mask and fifo state
	always_comb begin
		status_byte                 = 8'h00;
		status_byte[STAT_MASK_LIVE] = |mask;
		status_byte[STAT_FIFO_DATA] = rx_count != 8'h00;
	end

	// byte-done cycle writes and decodes, following step cycle reads and loads the next byte
	always_comb begin
		next_state      = state;
		next_kind       = kind;
		next_addr       = addr;
		next_mask_hi    = mask_hi;
		next_mask       = mask;
		next_hold       = hold;
		next_hold_addr  = hold_addr;
		next_hold_valid = hold_valid;
		next_step       = 1'b0;
		next_exc        = '0;
		mem_req         = '0;
		mem_req.addr    = addr;
		mem_req.wmask   = 8'hff;
		rx_pop          = 1'b0;
		load            = 1'b0;
		tx_byte         = status_byte;
		if (start) begin
			next_state      = ST_CMD;
			next_kind       = K_NONE;
			next_hold_valid = 1'b0;
			load            = 1'b1;
		end else if (done) begin
			next_step = 1'b1;
			unique case (state)
				ST_CMD: begin
					next_state = ST_ADDR_LO;
					next_addr  = {rx_byte[3:0], 8'h00};
					if (rx_byte[7:6] == GRP_LOW_READ || rx_byte[7:6] == GRP_LOW_WRITE) begin
						next_kind  = (rx_byte[7:6] == GRP_LOW_WRITE) ? K_WRITE : K_READ;
						next_addr  = {6'h00, rx_byte[5:0]};
						next_state = ST_DATA;
					end else begin
						case (rx_byte[7:4])
							GRP_MEM_READ:  next_kind = K_READ;
							GRP_MEM_WRITE: next_kind = K_WRITE;
							GRP_MEM_XOR:   next_kind = K_XOR;
							GRP_RX_COPY:   next_kind = K_RX_COPY;
							GRP_MISC: begin
								next_state = ST_IGNORE;
								case (rx_byte[3:0])
									SUB_RX_READ: begin
										next_kind  = K_RX_READ;
										next_state = ST_DATA;
									end
									SUB_MASK_AND: begin
										next_kind  = K_MASK;
										next_state = ST_MASK_HI;
									end
									SUB_BIT_SET: begin
										next_kind  = K_BIT_SET;
										next_state = ST_BIT;
									end
									SUB_BIT_CLEAR: begin
										next_kind  = K_BIT_CLEAR;
										next_state = ST_BIT;
									end
									default: next_state = ST_IGNORE;
								endcase
							end
							default: next_state = ST_IGNORE;
						endcase
					end
				end
				ST_ADDR_LO: begin
					next_addr[7:0] = rx_byte;
					next_state     = ST_DATA;
				end
				ST_MASK_HI: begin
					next_mask_hi = rx_byte;
					next_state   = ST_MASK_LO;
				end
				ST_MASK_LO: begin
					next_mask                         = and_result;
					next_exc.rx_enable_zero_exception = and_result == 16'h0000;
					next_state                        = ST_IGNORE;
				end
				ST_BIT: begin
					// masked write: other bits are neither written nor touched
					mem_req.addr  = {7'h00, rx_byte[7:3]};
					mem_req.wmask = 8'h01 << rx_byte[2:0];
					mem_req.wdata = (kind == K_BIT_SET) ? 8'hff : 8'h00;
					if (mem_req.addr <= MEM_TOP) begin
						mem_req.we = 1'b1;
					end else begin
						next_exc.memory_address_error = 1'b1;
					end
					next_state = ST_IGNORE;
				end
				ST_DATA: begin
					next_hold_valid = 1'b0;
					if (mem_kind) begin
						next_addr = addr_inc;
					end
					if (kind == K_WRITE || kind == K_XOR) begin
						if (in_range) begin
							mem_req.we    = 1'b1;
							mem_req.wdata = (kind == K_XOR) ? (rx_byte ^ mem_rdata) : rx_byte;
						end else begin
							next_exc.memory_address_error = 1'b1;
						end
					end
					if (kind == K_READ && !addr[0] && addr_inc <= MEM_TOP) begin
						mem_req.addr    = addr_inc;
						next_hold       = mem_rdata;
						next_hold_addr  = addr_inc;
						next_hold_valid = 1'b1;
					end
					// a fifo byte is removed, and copied, only after it has been shifted out in full
					if (rx_kind && hold_valid) begin
						rx_pop = 1'b1;
						if (kind == K_RX_COPY) begin
							next_addr = addr_inc;
							if (in_range) begin
								mem_req.we    = 1'b1;
								mem_req.wdata = hold;
							end else begin
								next_exc.memory_address_error = 1'b1;
							end
						end
					end else if (rx_kind) begin
						next_exc.rx_underflow = 1'b1;
					end
				end
				ST_IGNORE: begin
				end
			endcase
		end else if (step) begin
			load = 1'b1;
			if (state == ST_ADDR_LO && kind == K_RX_COPY) begin
				tx_byte = rx_count;
			end else if (state == ST_DATA && mem_kind) begin
				if (!in_range) begin
					tx_byte                       = 8'h00;
					next_exc.memory_address_error = 1'b1;
				end else begin
					tx_byte = hold_hit ? hold : mem_rdata;
				end
			end else if (state == ST_DATA && rx_kind) begin
				// present the head only; it leaves the fifo once shifted out, so a cut frame loses nothing
				tx_byte         = (rx_count != 8'h00) ? rx_data : 8'h00;
				next_hold       = rx_data;
				next_hold_valid = rx_count != 8'h00;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state      <= ST_CMD;
			kind       <= K_NONE;
			addr       <= 12'h000;
			mask_hi    <= 8'h00;
			mask       <= MASK_RESET;
			hold       <= 8'h00;
			hold_addr  <= 12'h000;
			hold_valid <= 1'b0;
			step       <= 1'b0;
			exc        <= '0;
		end else begin
			state      <= next_state;
			kind       <= next_kind;
			addr       <= next_addr;
			mask_hi    <= next_mask_hi;
			mask       <= next_mask;
			hold       <= next_hold;
			hold_addr  <= next_hold_addr;
			hold_valid <= next_hold_valid;
			step       <= next_step;
			exc        <= next_exc;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_mask_and_zero: assert property (done && state == ST_MASK_LO && and_result == 16'h0000 |=>
		exc.rx_enable_zero_exception && mask == 16'h0000) else $error("mask and zero not flagged");
	a_bit_set_one: assert property (done && state == ST_BIT && kind == K_BIT_SET && mem_req.we |->
		mem_req.wdata == 8'hff && mem_req.wmask == (8'h01 << rx_byte[2:0])) else $error("bit set wrong");
	a_bit_clear_zero: assert property (done && state == ST_BIT && kind == K_BIT_CLEAR && mem_req.we |->
		mem_req.wdata == 8'h00 && mem_req.addr == {7'h00, rx_byte[7:3]}) else $error("bit clear wrong");
	a_bit_single_lane: assert property (done && state == ST_BIT |-> $onehot(mem_req.wmask))
		else $error("bit op touches more than one bit");
	a_bit_range_low: assert property (done && state == ST_BIT && mem_req.we |->
		mem_req.addr < BIT_REGION_END) else $error("bit op outside low range");
	a_read_addr_step: assert property (done && state == ST_DATA && kind == K_READ |=>
		addr == $past(addr) + 12'h001 && step) else $error("read address did not advance");
	a_read_hold_latch: assert property (done && state == ST_DATA && kind == K_READ && !addr[0]
		&& addr_inc <= MEM_TOP |=> hold_valid && hold_addr == addr && tx_byte == hold) else $error("odd byte not latched");
	a_write_store_data: assert property (done && state == ST_DATA && kind == K_WRITE && in_range |->
		mem_req.we && mem_req.wdata == rx_byte && mem_req.addr == addr) else $error("write data lost");
	a_write_old_value: assert property (step && state == ST_DATA && kind == K_WRITE && in_range && !hold_hit |->
		load && tx_byte == mem_rdata && !mem_req.we) else $error("write did not return old value");
	a_low_region_start: assert property (done && state == ST_CMD && rx_byte[7] |=>
		state == ST_DATA && addr < LOW_REGION_END) else $error("low region start out of range");
	a_xor_write_data: assert property (done && state == ST_DATA && kind == K_XOR && in_range |->
		mem_req.we && mem_req.wdata == (rx_byte ^ mem_rdata)) else $error("xor write wrong");
	a_fifo_pop_data: assert property (step && state == ST_DATA && rx_kind && rx_count != 8'h00 |->
		load && tx_byte == rx_data && !rx_pop ##1 hold_valid && hold == rx_data) else $error("fifo byte not shown");
	a_fifo_pop_once: assert property (done && state == ST_DATA && rx_kind |-> rx_pop == hold_valid)
		else $error("fifo pop does not match shifted byte");
	a_fifo_underflow: assert property (done && state == ST_DATA && rx_kind && !hold_valid |->
		!rx_pop ##1 exc.rx_underflow) else $error("underflow not raised");
	a_copy_mem_write: assert property (done && state == ST_DATA && kind == K_RX_COPY && hold_valid
		&& in_range |-> mem_req.we && mem_req.wdata == rx_data ##1 addr == $past(addr) + 12'h001) else $error("copy lost");
	a_copy_count_byte: assert property (step && state == ST_ADDR_LO && kind == K_RX_COPY |->
		load && tx_byte == rx_count) else $error("count byte not sent");
	a_status_first: assert property (start |-> load && tx_byte == status_byte ##1 state == ST_CMD)
		else $error("status byte not first");
	a_addr_error_read: assert property (step && state == ST_DATA && mem_kind && !in_range |=>
		exc.memory_address_error) else $error("address error not raised");
endmodule
`default_nettype wire

// >>> rtl/spi_instr_pkg.sv
// Function
// - mask-and replaces receive-enable mask with mask AND operand; all-zero result raises exception.
// - bit-set writes one to bit index at 5-bit byte address.
// - bit-clear writes zero to bit index at 5-bit byte address.
// - single-bit operations leave other bits and their side effects untouched.
// - single-bit operations reach only byte addresses 0 to 31.
// - memory read returns byte at start address plus n on n-th transfer.
// - reading an even address latches the odd neighbour; next read returns the latch.
// - memory write stores n-th host byte at start address plus n.
// - memory and xor writes return the value held before the write.
// - low-region read and write behave as memory ones, starting below 0x40.
// - xor write stores host byte XOR current content at start plus n.
// - fifo read outputs oldest receive byte and removes it, each transfer.
// - fifo read with or without copy on empty fifo raises underflow.
// - fifo read with copy also writes each byte to consecutive memory addresses.
// - fifo read with copy shifts out the fifo byte count as second byte.
`default_nettype none
package spi_instr_pkg;
	// ----------------------------------------
	// instruction encoding
	// ----------------------------------------
	localparam logic [3:0] GRP_MEM_WRITE  = 4'h2;
	localparam logic [3:0] GRP_MEM_READ   = 4'h3;
	localparam logic [3:0] GRP_MEM_XOR    = 4'h4;
	localparam logic [3:0] GRP_RX_COPY    = 4'h5;
	localparam logic [3:0] GRP_MISC       = 4'h6;
	localparam logic [1:0] GRP_LOW_READ   = 2'h2;
	localparam logic [1:0] GRP_LOW_WRITE  = 2'h3;
	localparam logic [3:0] SUB_RX_READ    = 4'h0;
	localparam logic [3:0] SUB_MASK_AND   = 4'h1;
	localparam logic [3:0] SUB_BIT_SET    = 4'h2;
	localparam logic [3:0] SUB_BIT_CLEAR  = 4'h3;

	// ----------------------------------------
	// status byte, reset values, ranges
	// ----------------------------------------
	localparam int          STAT_MASK_LIVE  = 7;
	localparam int          STAT_FIFO_DATA  = 6;
	localparam logic [15:0] MASK_RESET      = 16'hffff;
	localparam logic [11:0] MEM_TOP_DEFAULT = 12'h3ff;
	localparam logic [11:0] LOW_REGION_END  = 12'h040;
	localparam logic [11:0] BIT_REGION_END  = 12'h020;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {ST_CMD, ST_ADDR_LO, ST_MASK_HI, ST_MASK_LO, ST_BIT, ST_DATA, ST_IGNORE} state_e;
	typedef enum logic [3:0] {K_NONE, K_READ, K_WRITE, K_XOR, K_RX_READ, K_RX_COPY, K_MASK, K_BIT_SET, K_BIT_CLEAR} kind_e;

	typedef struct packed {
		logic        cs_b;
		logic        sclk;
		logic        mosi;
	} spi_pins_s;

	typedef struct packed {
		logic        we;
		logic [7:0]  wmask;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} mem_req_s;

	typedef struct packed {
		logic        memory_address_error;
		logic        rx_underflow;
		logic        rx_enable_zero_exception;
	} exc_s;
endpackage
`default_nettype wire

// >>> rtl/spi_byte_shifter.sv
`default_nettype none
module spi_byte_shifter (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire spi_instr_pkg::spi_pins_s pins,
	input  wire logic [7:0]             tx_byte,
	input  wire logic                   load,
	output logic                        start,
	output logic                        done,
	output logic [7:0]                  rx_byte,
	output logic                        miso,
	output logic                        miso_oe
);
	import spi_instr_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic       cs_prev;
	logic       sclk_prev;

	// two flops per pin, then one more for edge detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1     <= 3'h4;
			sync2     <= 3'h4;
			cs_prev   <= 1'b1;
			sclk_prev <= 1'b0;
		end else begin
			sync1     <= {pins.cs_b, pins.sclk, pins.mosi};
			sync2     <= sync1;
			cs_prev   <= sync2[2];
			sclk_prev <= sync2[1];
		end
	end

	// ----------------------------------------
	// byte shifting, mode 0
	// ----------------------------------------
	logic       sel;
	logic       rise;
	logic       fall;
	logic [2:0] bits,    next_bits;
	logic [6:0] rx_sh,   next_rx_sh;
	logic [7:0] tx_sh,   next_tx_sh;
	logic       fresh,   next_fresh;
	logic       next_miso;
	logic [7:0] next_rx_byte;
	logic       next_done;
	logic       next_start;

	assign sel     = !sync2[2];
	assign rise    = sel && sync2[1] && !sclk_prev;
	assign fall    = sel && !sync2[1] && sclk_prev;
	assign miso_oe = sel;

	// sample on rising sclk, shift out on falling sclk
	always_comb begin
		next_bits    = bits;
		next_rx_sh   = rx_sh;
		next_tx_sh   = tx_sh;
		next_fresh   = fresh;
		next_miso    = miso;
		next_rx_byte = rx_byte;
		next_done    = 1'b0;
		next_start   = cs_prev && sel;
		if (!sel) begin
			next_bits  = 3'h0;
			next_fresh = 1'b1;
		end else begin
			if (rise) begin
				next_bits  = bits + 3'h1;
				next_rx_sh = {rx_sh[5:0], sync2[0]};
				if (bits == 3'h7) begin
					next_rx_byte = {rx_sh, sync2[0]};
					next_done    = 1'b1;
				end
			end
			if (load && fresh) begin
				next_miso  = tx_byte[7]; // first bit goes out before the first sclk edge
				next_tx_sh = {tx_byte[6:0], 1'b0};
				next_fresh = 1'b0;
			end else if (load) begin
				next_tx_sh = tx_byte;
			end else if (fall) begin
				next_miso  = tx_sh[7];
				next_tx_sh = {tx_sh[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bits    <= 3'h0;
			rx_sh   <= 7'h00;
			tx_sh   <= 8'h00;
			fresh   <= 1'b1;
			miso    <= 1'b0;
			rx_byte <= 8'h00;
			done    <= 1'b0;
			start   <= 1'b0;
		end else begin
			bits    <= next_bits;
			rx_sh   <= next_rx_sh;
			tx_sh   <= next_tx_sh;
			fresh   <= next_fresh;
			miso    <= next_miso;
			rx_byte <= next_rx_byte;
			done    <= next_done;
			start   <= next_start;
		end
	end
endmodule
`default_nettype wire

// >>> verification/spi_host_model.sv
`default_nettype none
module spi_host_model (
	input  wire logic                         clk,
	output var spi_instr_pkg::spi_pins_s      pins,
	input  wire logic                         miso,
	input  wire logic                         miso_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	import spi_instr_pkg::*;

	// ----------------------------------------
	// spi master, mode 0, msb first
	// ----------------------------------------
	logic [7:0] tx [0:7];
	logic [7:0] rx [0:7];
	logic       oe_ok;

	// link idle: deselected, clock low
	initial pins = '{cs_b: 1'b1, sclk: 1'b0, mosi: 1'b0};

	// wait whole cycles, then step just past the edge
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// one frame of n bytes; fifo reads only come from the bench, which never starts a background move
	task automatic run(input int n);
		oe_ok = 1'b1;
		step(1);
		pins.cs_b = 1'b0;
		for (int i = 0; i < n; i++) begin
			for (int b = 7; b >= 0; b--) begin
				pins.mosi = tx[i][b];
				step((i == 0 && b == 7) ? 8 : 4);
				pins.sclk = 1'b1;
				rx[i][b] = miso;
				oe_ok &= miso_oe;
				step(4);
				pins.sclk = 1'b0;
			end
		end
		step(4);
		pins.cs_b = 1'b1;
		pins.mosi = ~pins.mosi; // released line shows no stale bit
		step(12);
	endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import spi_instr_pkg::*;

	// ----------------------------------------
	// signals and models
	// ----------------------------------------
	localparam logic [11:0] TOP = 12'h07f;

	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	spi_pins_s   pins;
	logic        miso, miso_oe, rx_pop;
	mem_req_s    mem_req;
	logic [7:0]  mem_rdata, rx_count, rx_data, v;
	logic [7:0]  last_pop = 8'h00;
	logic [15:0] rx_enable_mask, mask_m;
	exc_s        exc;
	logic [7:0]  mem [0:4095];
	logic [7:0]  mdl [0:4095];
	logic [7:0]  fifo [0:15];
	logic [3:0]  rd_ptr = 4'h0;
	logic [3:0]  wr_ptr = 4'h0;
	logic [7:0]  exp_rx [0:7];
	logic        seen_addr, seen_under, seen_zero;
	int          n_pop, errors = 0, num_checks = 0;

	typedef struct packed {logic [7:0] op; logic [11:0] a; logic [7:0] d;} row_s;
	// opcode group, start address, data base (frame byte i carries base plus i)
	row_s rows [0:7] = '{
		'{8'h20, 12'h010, 8'h11}, '{8'h30, 12'h00f, 8'h00}, '{8'h40, 12'h011, 8'hf0}, '{8'h80, 12'h03e, 8'h00},
		'{8'hc0, 12'h03f, 8'h33}, '{8'h30, 12'h03e, 8'h00}, '{8'h20, 12'h07d, 8'h44}, '{8'h30, 12'h07c, 8'h00}};

	always #5 clk = ~clk;

	spi_memory_fifo_instruction_unit #(.MEM_TOP(TOP)) dut (
		.clk(clk), .rst_b(rst_b), .pins(pins), .miso(miso), .miso_oe(miso_oe), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .rx_count(rx_count), .rx_data(rx_data), .rx_pop(rx_pop),
		.rx_enable_mask(rx_enable_mask), .exc(exc));
	spi_host_model host (.clk(clk), .pins(pins), .miso(miso), .miso_oe(miso_oe));

	// combinational memory read and fifo head; an empty fifo shows no stale byte
	assign mem_rdata = mem[mem_req.addr];
	assign rx_count  = {4'h0, wr_ptr - rd_ptr};
	assign rx_data   = (rx_count != 8'h00) ? fifo[rd_ptr] : ~last_pop;

	// masked memory write, fifo pop and exception watchers
	always @(posedge clk) begin
		if (mem_req.we)
			mem[mem_req.addr] <= (mem[mem_req.addr] & ~mem_req.wmask) | (mem_req.wdata & mem_req.wmask);
		if (rx_pop && rx_count != 8'h00) begin
			last_pop <= rx_data;
			rd_ptr   <= rd_ptr + 4'h1;
		end
		if (rx_pop)
			n_pop <= n_pop + 1;
		if (exc.memory_address_error)
			seen_addr <= 1'b1;
		if (exc.rx_underflow)
			seen_under <= 1'b1;
		if (exc.rx_enable_zero_exception)
			seen_zero <= 1'b1;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_mask(input string what, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_flag(input string what, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	function automatic logic [7:0] status();
		return {mask_m != 16'h0000, rx_count != 8'h00, 6'h00};
	endfunction

	task automatic xfer(input int n, input logic [7:0] b0, b1, b2, b3, b4);
		host.tx[0] = b0;
		host.tx[1] = b1;
		host.tx[2] = b2;
		host.tx[3] = b3;
		host.tx[4] = b4;
		host.run(n);
	endtask

	task automatic want(input logic [7:0] b0, b1, b2, b3, b4);
		exp_rx = '{b0, b1, b2, b3, b4, 8'h00, 8'h00, 8'h00};
	endtask

	task automatic chk_rx(input int n);
		chk_flag("miso_oe in frame", 1'b1, host.oe_ok);
		for (int i = 0; i < n; i++)
			chk_byte("miso byte", exp_rx[i], host.rx[i]);
	endtask

	task automatic clr();
		{seen_addr, seen_under, seen_zero} = 3'b000;
		n_pop = 0;
	endtask

	task automatic push(input logic [7:0] b);
		fifo[wr_ptr] = b;
		wr_ptr = wr_ptr + 4'h1;
	endtask

	// reset held 8 cycles; outputs checked while it is held
	task automatic do_reset();
		rst_b = 1'b0;
		mask_m = 16'hffff;
		host.step(8);
		chk_byte("miso oe we pop", 8'h00, {4'h0, miso, miso_oe, mem_req.we, rx_pop});
		chk_byte("exceptions", 8'h00, {5'h00, exc});
		chk_mask("mask at reset", 16'hffff, rx_enable_mask);
		rst_b = 1'b1;
		host.step(4);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int          ds;
		logic [11:0] a;
		logic [11:0] x;
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
			mdl[i] = mem[i];
		end
		clr();
		do_reset();
		// table of plain reads, writes and xor writes
		foreach (rows[r]) begin
			ds = rows[r].op[7] ? 1 : 2;
			a = rows[r].a;
			for (int i = 0; i < 5; i++) begin
				x = a + 12'(i - ds);
				host.tx[i] = (i == 0) ? (rows[r].op[7] ? {rows[r].op[7:6], a[5:0]} : {rows[r].op[7:4], a[11:8]})
					: (i < ds) ? a[7:0] : rows[r].d + 8'(i);
				exp_rx[i] = (i < ds) ? status() : mdl[x];
				if (i >= ds && (rows[r].op == 8'h20 || rows[r].op == 8'hc0))
					mdl[x] = host.tx[i];
				if (i >= ds && rows[r].op == 8'h40)
					mdl[x] = mdl[x] ^ host.tx[i];
			end
			host.run(5);
			chk_rx(5);
			for (int i = 0; i < 5; i++)
				chk_byte("memory", mdl[a + 12'(i)], mem[a + 12'(i)]);
		end
		// word read stays whole when the odd byte changes mid-transfer
		v = mem[12'h021];
		fork
			begin
				host.step(197); // just after the even byte's latch, before the odd byte is loaded
				mem[12'h021] = ~v;
			end
		join_none
		want(8'h80, 8'h80, mdl[12'h020], v, mdl[12'h022]);
		xfer(5, 8'h30, 8'h20, 8'h00, 8'h00, 8'h00);
		chk_rx(5);
		mdl[12'h021] = ~v;
		// accesses past the top of memory
		clr();
		want(8'h80, 8'h80, mdl[TOP], 8'h00, 8'h00);
		xfer(4, 8'h30, 8'h7f, 8'h00, 8'h00, 8'h00);
		chk_rx(4);
		chk_flag("read address error", 1'b1, seen_addr);
		clr();
		v = mem[12'h080];
		want(8'h80, 8'h80, mdl[TOP], 8'h00, 8'h00);
		xfer(4, 8'h20, 8'h7f, 8'haa, 8'hbb, 8'h00);
		chk_rx(4);
		chk_byte("last legal byte", 8'haa, mem[TOP]);
		chk_byte("skipped byte", v, mem[12'h080]);
		chk_flag("write address error", 1'b1, seen_addr);
		// every bit index set, then cleared, at the highest bit address
		mem[31] = 8'h00;
		v = 8'h00;
		for (int b = 0; b < 16; b++) begin
			v = (b < 8) ? (v | (8'h01 << b)) : (v & ~(8'h01 << (b - 8)));
			want(8'h80, 8'h80, 8'h00, 8'h00, 8'h00);
			xfer(2, (b < 8) ? 8'h62 : 8'h63, {5'd31, 3'(b)}, 8'h00, 8'h00, 8'h00);
			chk_rx(2);
			chk_byte("bit target", v, mem[31]);
		end
		// fifo read running past the last byte
		push(8'hc1);
		push(8'hc2);
		push(8'hc3);
		clr();
		want(8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'h00);
		xfer(5, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00);
		chk_rx(5);
		chk_byte("pops", 8'h03, 8'(n_pop));
		chk_flag("underflow", 1'b1, seen_under);
		clr();
		want(8'h80, 8'h00, 8'h00, 8'h00, 8'h00);
		xfer(2, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00);
		chk_rx(2);
		chk_flag("empty underflow", 1'b1, seen_under);
		// fifo read with copy into memory
		push(8'hd1);
		push(8'hd2);
		clr();
		want(8'hc0, 8'h02, 8'hd1, 8'hd2, 8'h00);
		xfer(5, 8'h50, 8'h50, 8'h00, 8'h00, 8'h00);
		chk_rx(5);
		chk_byte("copy first", 8'hd1, mem[12'h050]);
		chk_byte("copy second", 8'hd2, mem[12'h051]);
		chk_flag("copy underflow", 1'b1, seen_under);
		// a frame cut after one fifo byte takes only that byte
		push(8'he1);
		push(8'he2);
		clr();
		want(8'hc0, 8'he1, 8'h00, 8'h00, 8'h00);
		xfer(2, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00);
		chk_rx(2);
		chk_byte("pops after short read", 8'h01, 8'(n_pop));
		chk_flag("short read underflow", 1'b0, seen_under);
		want(8'hc0, 8'he2, 8'h00, 8'h00, 8'h00);
		xfer(2, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00);
		chk_rx(2);
		chk_byte("pops after drain", 8'h02, 8'(n_pop));
		// mask and: narrowing, then to zero
		clr();
		want(8'h80, 8'h80, 8'h80, 8'h00, 8'h00);
		xfer(3, 8'h61, 8'h0f, 8'hf0, 8'h00, 8'h00);
		chk_rx(3);
		chk_mask("mask", 16'h0ff0, rx_enable_mask);
		chk_flag("no zero exception", 1'b0, seen_zero);
		xfer(3, 8'h61, 8'hf0, 8'h0f, 8'h00, 8'h00);
		chk_rx(3);
		chk_mask("mask", 16'h0000, rx_enable_mask);
		chk_flag("zero exception", 1'b1, seen_zero);
		mask_m = 16'h0000;
		want(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		xfer(2, 8'h62, 8'h00, 8'h00, 8'h00, 8'h00);
		chk_rx(2);
		do_reset();
		report_and_stop();
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
